// ==== bce_cfg.svh ====
`ifndef BCE_CFG_SVH
`define BCE_CFG_SVH

// APB byte addresses of the register words.
`define BCE_ADDR_W            12
`define BCE_ADDR_INSN         12'h000
`define BCE_ADDR_CTRL         12'h004
`define BCE_ADDR_STATUS       12'h008
`define BCE_ADDR_COUNT        12'h00c

// Field positions inside the condition word.
`define BCE_MASK_LSB          0
`define BCE_MASK_MSB          3
`define BCE_STATE_LSB         4
`define BCE_STATE_MSB         7
`define BCE_SEL_LSB           8
`define BCE_SEL_MSB           9
`define BCE_INSN_W            10

// Bit positions of the four conditions in a flag condition field.
`define BCE_FLAG_ZERO         3
`define BCE_FLAG_NEG          2
`define BCE_FLAG_OVF          1
`define BCE_FLAG_CARRY        0

// Control word fields.
`define BCE_CTRL_CORE_EN      0

// Status word fields.
`define BCE_STAT_COND_MET     0
`define BCE_STAT_SEL_MET      1
`define BCE_STAT_FLAG_MET     2
`define BCE_STAT_IO_LEVEL     3
`define BCE_STAT_FLAGS_LSB    4
`define BCE_STAT_FLAGS_MSB    7

// Reset values.
`define BCE_RST_INSN          10'h300
`define BCE_RST_CTRL          1'h1
`define BCE_COUNT_W           16

`endif

// ==== bce_pkg.sv ====
package bce_pkg;

   // Meaning of the two-bit branch condition select field.
   typedef enum logic [1:0] {
      BCE_SEL_IO_LOW   = 2'h0,
      BCE_SEL_TEST_SET = 2'h1,
      BCE_SEL_TEST_CLR = 2'h2,
      BCE_SEL_NONE     = 2'h3
   } bce_cond_sel_type;

   // One flag condition field: zero, negative, overflow, carry from msb down.
   typedef logic [3:0] bce_flag_field_type;

endpackage

// ==== bce_cond_eval.sv ====
`timescale 1ns/1ps
`include "bce_cfg.svh"

// Purely combinational evaluator of one condition word against a snapshot.
module bce_cond_eval #(
   parameter int RESULT_W = 32
) (
   input  wire logic                          [1:0] i_sel,
   input  wire bce_pkg::bce_flag_field_type         i_mask,
   input  wire bce_pkg::bce_flag_field_type         i_state,
   input  wire logic                   [RESULT_W-1:0] i_result,
   input  wire logic                                i_overflow,
   input  wire logic                                i_carry,
   input  wire logic                                i_test_flag,
   input  wire logic                                i_io_level,
   output logic                                     o_sel_met,
   output logic                                     o_flag_met,
   output logic                                     o_cond_met,
   output bce_pkg::bce_flag_field_type              o_flags
);

   // Builds the live flag condition field from the result register, overflow and carry.
   function automatic bce_pkg::bce_flag_field_type flag_states(
      input logic [RESULT_W-1:0] result,
      input logic                ovf,
      input logic                carry
   );
      bce_pkg::bce_flag_field_type f;
      f = 4'h0;
      f[`BCE_FLAG_ZERO]  = (result == '0);      // [RULE2]
      f[`BCE_FLAG_NEG]   = result[RESULT_W-1];  // [RULE2]
      f[`BCE_FLAG_OVF]   = ovf;                 // [RULE2]
      f[`BCE_FLAG_CARRY] = carry;               // [RULE2]
      return f;
   endfunction

   bce_pkg::bce_flag_field_type hits;   // Tested conditions that match.

   // Select field decode; the io input is active low.
   always_comb begin
      case (bce_pkg::bce_cond_sel_type'(i_sel))
         bce_pkg::BCE_SEL_IO_LOW:   o_sel_met = ~i_io_level;   // [RULE1]
         bce_pkg::BCE_SEL_TEST_SET: o_sel_met = i_test_flag;   // [RULE1]
         bce_pkg::BCE_SEL_TEST_CLR: o_sel_met = ~i_test_flag;  // [RULE1]
         bce_pkg::BCE_SEL_NONE:     o_sel_met = 1'b1;          // [RULE1]
         default:                   o_sel_met = 1'b1;
      endcase
   end

   // Flag field test. A state bit matches when it equals the live flag;
   // the mask picks the tested ones and any surviving bit meets it.
   // A zero mask tests nothing, so that part does not block the outcome.
   always_comb begin
      o_flags    = flag_states(i_result, i_overflow, i_carry);
      hits       = i_mask & ~(i_state ^ o_flags);         // [RULE3] [RULE4] [RULE5] [RULE6]
      o_flag_met = (i_mask == 4'h0) ? 1'b1 : (|hits);     // [RULE5]
      o_cond_met = o_sel_met & o_flag_met;
   end

endmodule

// ==== bce_branch_cond.sv ====
// What this block does
// (RULE1) Select field picks io-low, flag set, flag clear, none.
// (RULE2) Flag field holds zero, negative, overflow, carry.
// (RULE3) Low four bits mask which conditions are tested.
// (RULE4) Bits four to seven give required states.
// (RULE5) Mask AND matches; any set bit means met.
// (RULE6) Greater-or-equal uses zero, negative mask; zero state.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "bce_cfg.svh"

module bce_branch_cond #(
   parameter int RESULT_W = 32,           // Width of the result register.
   parameter int COUNT_W  = `BCE_COUNT_W  // Width of the met counter.
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_n,
   // Instruction decode side of the core.
   input  wire logic                  i_insn_valid,
   input  wire logic [`BCE_INSN_W-1:0] i_insn,
   input  wire logic   [RESULT_W-1:0] i_result_register,
   input  wire logic                  i_overflow,
   input  wire logic                  i_carry,
   input  wire logic                  i_test_control_flag,
   // Asynchronous pin, active low branch request.
   input  wire logic                  i_io_branch_input,
   // APB slave.
   input  wire logic                  i_psel,
   input  wire logic                  i_penable,
   input  wire logic                  i_pwrite,
   input  wire logic [`BCE_ADDR_W-1:0] i_paddr,
   input  wire logic           [31:0] i_pwdata,
   output logic                       o_pready,
   output logic               [31:0] o_prdata,
   output logic                       o_pslverr,
   // Outcome towards the branch unit.
   output logic                       o_eval_valid,
   output logic                       o_cond_met
);

   // Three-stage capture of the io pin.
   logic io_sync1_ff;                   // First stage, only feeds the second.
   logic io_sync2_ff;                   // Second stage.
   logic io_sync3_ff;                   // Third stage.
   logic io_level_ff;                   // Accepted pin level.

   // Register file.
   logic [`BCE_INSN_W-1:0] insn_reg_ff; // Software condition word.
   logic                   core_en_ff;  // Core instructions are evaluated.
   logic     [COUNT_W-1:0] count_ff;    // Number of met evaluations.

   // Evaluation pipeline.
   logic                   req_ff;      // Snapshot holds a pending request.
   logic [`BCE_INSN_W-1:0] snap_insn_ff;
   logic    [RESULT_W-1:0] snap_result_ff;
   logic                   snap_ovf_ff;
   logic                   snap_carry_ff;
   logic                   snap_test_ff;
   logic                   snap_io_ff;

   // Outcome of the last evaluation, kept for status reads.
   logic                   sel_met_ff;
   logic                   flag_met_ff;
   bce_pkg::bce_flag_field_type flags_ff;

   // APB signals.
   logic                   setup;       // Setup phase of a transfer.
   logic                   access;      // Access edge at which a transfer ends.
   logic                   wr_insn;     // Write to the condition word.
   logic                   wr_ctrl;     // Write to the control word.
   logic                   wr_count;    // Write clears the counter.
   logic                   core_req;    // Accepted core request.
   logic                   nxt_req;     // A request is taken this cycle.
   logic [`BCE_INSN_W-1:0] nxt_insn;    // Word that the request evaluates.
   logic            [31:0] nxt_prdata;  // Read data for the coming access.
   logic                   nxt_pslverr; // Unmapped address flag.

   // Evaluator answers.
   logic                   ev_sel_met;
   logic                   ev_flag_met;
   logic                   ev_cond_met;
   bce_pkg::bce_flag_field_type ev_flags;

   // True when an address hits one of the four register words.
   function automatic logic addr_mapped(input logic [`BCE_ADDR_W-1:0] a);
      return (a == `BCE_ADDR_INSN) || (a == `BCE_ADDR_CTRL) ||
             (a == `BCE_ADDR_STATUS) || (a == `BCE_ADDR_COUNT);
   endfunction

   // The pin passes three flops; only the second reads the first.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         io_sync1_ff <= 1'b1;
         io_sync2_ff <= 1'b1;
         io_sync3_ff <= 1'b1;
      end else begin
         io_sync1_ff <= i_io_branch_input;
         io_sync2_ff <= io_sync1_ff;
         io_sync3_ff <= io_sync2_ff;
      end
   end

   // A change is accepted only once the last two stages agree, which
   // filters a pin that is still settling. Idle level is high.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         io_level_ff <= 1'b1;
      end else if (io_sync2_ff == io_sync3_ff) begin
         io_level_ff <= io_sync3_ff;
      end
   end

   // Bus phase decode. The slave never inserts wait states, so every
   // access phase completes at its first edge.
   always_comb begin
      setup    = i_psel & ~i_penable;
      access   = i_psel & i_penable & o_pready;
      wr_insn  = access & i_pwrite & (i_paddr == `BCE_ADDR_INSN);
      wr_ctrl  = access & i_pwrite & (i_paddr == `BCE_ADDR_CTRL);
      wr_count = access & i_pwrite & (i_paddr == `BCE_ADDR_COUNT);
   end

   // Ready rises for the access phase and falls right after it.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_pready <= 1'b0;
      end else begin
         o_pready <= setup;
      end
   end

   // Read data and the error answer are prepared during setup so that
   // both come straight from flops in the access phase.
   always_comb begin
      nxt_prdata  = 32'h0000_0000;
      nxt_pslverr = ~addr_mapped(i_paddr);
      if (!i_pwrite) begin
         case (i_paddr)
            `BCE_ADDR_INSN: begin
               nxt_prdata[`BCE_INSN_W-1:0] = insn_reg_ff;
            end
            `BCE_ADDR_CTRL: begin
               nxt_prdata[`BCE_CTRL_CORE_EN] = core_en_ff;
            end
            `BCE_ADDR_STATUS: begin
               nxt_prdata[`BCE_STAT_COND_MET] = o_cond_met;
               nxt_prdata[`BCE_STAT_SEL_MET]  = sel_met_ff;
               nxt_prdata[`BCE_STAT_FLAG_MET] = flag_met_ff;
               nxt_prdata[`BCE_STAT_IO_LEVEL] = io_level_ff;
               nxt_prdata[`BCE_STAT_FLAGS_MSB:`BCE_STAT_FLAGS_LSB] = flags_ff;
            end
            `BCE_ADDR_COUNT: begin
               nxt_prdata[COUNT_W-1:0] = count_ff;
            end
            default: begin
               nxt_prdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // Read data register; it holds between transfers, while the error flag clears at the access edge.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else if (setup) begin
         o_prdata  <= nxt_prdata;
         o_pslverr <= nxt_pslverr;
      end else if (access) begin
         o_pslverr <= 1'b0;
      end
   end

   // Software condition word; only the low ten bits are stored.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         insn_reg_ff <= `BCE_RST_INSN;
      end else if (wr_insn) begin
         insn_reg_ff <= i_pwdata[`BCE_INSN_W-1:0];
      end
   end

   // Control word: gates the core's own request path.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         core_en_ff <= `BCE_RST_CTRL;
      end else if (wr_ctrl) begin
         core_en_ff <= i_pwdata[`BCE_CTRL_CORE_EN];
      end
   end

   // Request source. The core wins over a software write in the same
   // cycle because a stalled branch costs more than a retried probe;
   // the written word is still stored, but only for read-back; it is never evaluated.
   always_comb begin
      core_req = i_insn_valid & core_en_ff;
      nxt_req  = core_req | wr_insn;
      nxt_insn = core_req ? i_insn : i_pwdata[`BCE_INSN_W-1:0];
   end

   // Snapshot of the word and the live conditions at the request edge,
   // so that a flag moving in the next cycle cannot skew the outcome.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         snap_insn_ff   <= `BCE_RST_INSN;
         snap_result_ff <= '0;
         snap_ovf_ff    <= 1'b0;
         snap_carry_ff  <= 1'b0;
         snap_test_ff   <= 1'b0;
         snap_io_ff     <= 1'b1;
      end else if (nxt_req) begin
         snap_insn_ff   <= nxt_insn;
         snap_result_ff <= i_result_register;
         snap_ovf_ff    <= i_overflow;
         snap_carry_ff  <= i_carry;
         snap_test_ff   <= i_test_control_flag;
         snap_io_ff     <= io_level_ff;
      end
   end

   // Marks the cycle in which the snapshot is fresh.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         req_ff <= 1'b0;
      end else begin
         req_ff <= nxt_req;
      end
   end

   // Condition evaluator on the snapshot.
   bce_cond_eval #(
      .RESULT_W (RESULT_W)
   ) u_eval (
      .i_sel       (snap_insn_ff[`BCE_SEL_MSB:`BCE_SEL_LSB]),     // [RULE1]
      .i_mask      (snap_insn_ff[`BCE_MASK_MSB:`BCE_MASK_LSB]),   // [RULE3]
      .i_state     (snap_insn_ff[`BCE_STATE_MSB:`BCE_STATE_LSB]), // [RULE4]
      .i_result    (snap_result_ff),
      .i_overflow  (snap_ovf_ff),
      .i_carry     (snap_carry_ff),
      .i_test_flag (snap_test_ff),
      .i_io_level  (snap_io_ff),
      .o_sel_met   (ev_sel_met),
      .o_flag_met  (ev_flag_met),
      .o_cond_met  (ev_cond_met),
      .o_flags     (ev_flags)
   );

   // Outcome registers; the level holds until the next evaluation.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_cond_met  <= 1'b0;
         sel_met_ff  <= 1'b0;
         flag_met_ff <= 1'b0;
         flags_ff    <= 4'h0;
      end else if (req_ff) begin
         o_cond_met  <= ev_cond_met;   // [RULE5] [RULE6]
         sel_met_ff  <= ev_sel_met;
         flag_met_ff <= ev_flag_met;
         flags_ff    <= ev_flags;
      end
   end

   // One-cycle strobe that the outcome just changed hands.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_eval_valid <= 1'b0;
      end else begin
         o_eval_valid <= req_ff;
      end
   end

   // Met counter. A clear and a met result in the same cycle leave one,
   // so no event is lost; it saturates rather than wrapping to zero.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         count_ff <= '0;
      end else if (wr_count) begin
         count_ff <= (req_ff && ev_cond_met) ? COUNT_W'(1) : '0;
      end else if (req_ff && ev_cond_met && (count_ff != '1)) begin
         count_ff <= count_ff + COUNT_W'(1);
      end
   end

endmodule

// ==== bce_branch_cond_asserts.sv ====
`timescale 1ns/1ps
// Port-level checker; expectations are rebuilt from the inputs seen at the request edge.
module bce_branch_cond_asserts #(
   parameter int RESULT_W = 32,  // Width of the result register.
   parameter int COUNT_W  = 16   // Width of the met counter.
) (
   input  wire logic                i_clk,
   input  wire logic                i_rst_n,
   input  wire logic                i_insn_valid,
   input  wire logic [9:0]          i_insn,
   input  wire logic [RESULT_W-1:0] i_result_register,
   input  wire logic                i_overflow,
   input  wire logic                i_carry,
   input  wire logic                i_test_control_flag,
   input  wire logic                i_psel,
   input  wire logic                i_penable,
   input  wire logic                i_pwrite,
   input  wire logic [11:0]         i_paddr,
   input  wire logic                o_pready,
   input  wire logic                o_pslverr,
   input  wire logic                o_eval_valid,
   input  wire logic                o_cond_met
);
   logic [3:0] flg;  // Zero, negative, overflow, carry as seen now.
   logic       fm;   // Flag part met, mask zero counts as met.
   logic       sm;   // Select part met; the pin case is left out.
   logic       vs;   // Request with select none, so only flags decide.
   logic       vf;   // Request with an empty mask, so only the select decides.
   logic       wr;   // Access phase of a write to the condition word.
   logic       st;   // Setup phase of any transfer.
   assign flg = {i_result_register == '0, i_result_register[RESULT_W-1], i_overflow, i_carry};
   assign fm  = i_insn[3:0] == 4'h0 || |(i_insn[3:0] & ~(i_insn[7:4] ^ flg));
   assign sm  = i_insn[9:8] == 2'h3 || (i_insn[8] ? i_test_control_flag : !i_test_control_flag);
   assign vs  = i_insn_valid && i_insn[9:8] == 2'h3;
   assign vf  = i_insn_valid && i_insn[9:8] != 2'h0 && i_insn[3:0] == 4'h0;
   assign wr  = i_psel && i_penable && i_pwrite && i_paddr == 12'h000;
   assign st  = i_psel && !i_penable;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   AST_SETUP_READY: assert property (st |=> o_pready)
      else $error("ready missing after setup");
   AST_ERR_UNMAPPED: assert property (o_pslverr |-> o_pready && (i_paddr > 12'h00c || i_paddr[1:0] != 2'h0))
      else $error("error on a mapped address");
   AST_EVAL_CAUSE: assert property (o_eval_valid |-> $past(i_insn_valid, 2) || $past(wr, 2))
      else $error("evaluation pulse without request");
   AST_SELECT: assert property (o_eval_valid && $past(vf, 2) |-> o_cond_met == $past(sm, 2))
      else $error("select outcome wrong");
   AST_FLAGS: assert property (o_eval_valid && $past(vs, 2) |-> o_cond_met == $past(fm, 2))
      else $error("flag outcome wrong");
   AST_CARRY: assert property (o_eval_valid && $past(vs && i_insn[7:0] == 8'h11, 2) |-> o_cond_met == $past(i_carry, 2))
      else $error("carry outcome wrong");
   AST_GE_ZERO: assert property (o_eval_valid && $past(vs && i_insn[7:0] == 8'h8c, 2) |-> o_cond_met != $past(flg[2], 2))
      else $error("greater or equal outcome wrong");
   AST_HOLD: assert property (!o_eval_valid && $past(i_rst_n) |-> $stable(o_cond_met))
      else $error("outcome moved without evaluation");
endmodule

// ==== bce_core_model.sv ====
`timescale 1ns/1ps
// Stand-in for the core's decode unit: issues one request per command and logs outcomes.
module bce_core_model (
   input  wire logic        i_clk,
   input  wire logic        i_issue,       // One-cycle command from the bench.
   input  wire logic [44:0] i_cmd,         // Word, result, overflow, carry, test flag.
   input  wire logic        i_eval_valid,
   input  wire logic        i_cond_met,
   output logic             o_insn_valid,
   output logic [9:0]       o_insn,
   output logic [31:0]      o_result,
   output logic [2:0]       o_vct,         // Overflow, carry, test flag.
   output logic             o_met,
   output logic [7:0]       o_seen         // Outcomes received so far.
);
   initial begin
      o_insn_valid = 1'b0;
      o_insn = 10'h000;
      o_result = 32'h0;
      o_vct = 3'h0;
      o_met = 1'b0;
      o_seen = 8'h00;
   end
   // The word is meaningless between requests, so it wanders instead of holding.
   always @(posedge i_clk) begin
      o_insn_valid <= i_issue;
      o_insn       <= i_issue ? i_cmd[44:35] : ~o_insn;
      if (i_issue) begin
         o_result <= i_cmd[34:3];
         o_vct <= i_cmd[2:0];
      end
      if (i_eval_valid) begin
         o_met  <= i_cond_met;
         o_seen <= o_seen + 8'h01;
      end
   end
endmodule

// ==== bce_branch_cond_test.sv ====
`timescale 1ns/1ps
module bce_branch_cond_test;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, ev, cm, io, issue, iv, met;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, res, rd;
   logic [44:0] cmd;
   logic [9:0]  insn;
   logic [2:0]  vct;
   logic [7:0]  seen;
   logic        er;
   int          n_mismatch, cmp_count, n_met;
   bce_branch_cond #(.RESULT_W(32), .COUNT_W(16)) u_bce_branch_cond (
      .i_clk(clk), .i_rst_n(rst_n), .i_insn_valid(iv), .i_insn(insn), .i_result_register(res),
      .i_overflow(vct[2]), .i_carry(vct[1]), .i_test_control_flag(vct[0]), .i_io_branch_input(io),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .o_eval_valid(ev), .o_cond_met(cm));
   bce_core_model u_bce_core_model (.i_clk(clk), .i_issue(issue), .i_cmd(cmd), .i_eval_valid(ev),
      .i_cond_met(cm), .o_insn_valid(iv), .o_insn(insn), .o_result(res), .o_vct(vct), .o_met(met), .o_seen(seen));
   // Clock at 20 MHz.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One APB transfer; waits for ready under a bound.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_mismatch++;
         print_verdict();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Bounded wait for the next outcome, then compare it with the expected one.
   task automatic wait_eval(input logic [7:0] s, input logic e);
      for (int n = 0; n < 12 && seen === s; n++) begin
         @(posedge clk);
      end
      if (seen === s) begin
         n_mismatch++;
         print_verdict();
      end
      check(met, e);
      n_met += e;
   endtask
   function automatic logic exp_met(input logic [9:0] w, input logic [31:0] a, input logic [2:0] f);
      logic [3:0] z;
      logic       s;
      z = {a == 32'h0, a[31], f[2:1]};
      s = w[9:8] == 2'h0 ? !io : w[9:8] == 2'h1 ? f[0] : w[9:8] == 2'h2 ? !f[0] : 1'b1;
      return s && (w[3:0] == 4'h0 || |(w[3:0] & ~(w[7:4] ^ z)));
   endfunction
   task automatic core(input logic [9:0] w, input logic [31:0] a, input logic [2:0] f);
      logic [7:0] s;
      @(posedge clk);
      s = seen;
      issue <= 1'b1;
      cmd <= {w, a, f};
      @(posedge clk);
      issue <= 1'b0;
      wait_eval(s, exp_met(w, a, f));
   endtask
   // Reset values, unmapped access and a read-only write.
   task automatic t_regs();
      apb(1'b0, 12'h000, 32'h0);
      check(rd, 32'h300);
      apb(1'b0, 12'h004, 32'h0);
      check(rd, 32'h1);
      apb(1'b1, 12'h008, 32'hff);
      check(er, 1'b0);
      apb(1'b0, 12'h008, 32'h0);
      check(rd, 32'h08);
      apb(1'b0, 12'h00c, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      check(er, 1'b1);
      check(rd, 32'h0);
   endtask
   // Every select code, both test flag states and both pin levels.
   task automatic t_select();
      for (int k = 2; k < 8; k++) begin
         core({k[2:1], 8'h00}, 32'h1, {2'h0, k[0]});
      end
      io <= 1'b0;
      repeat (8) @(posedge clk);
      core(10'h000, 32'h1, 3'h0);
      io <= 1'b1;
      repeat (8) @(posedge clk);
      core(10'h000, 32'h1, 3'h0);
   endtask
   // Masks, states and flag patterns; then the greater-or-equal code on three results.
   task automatic t_flags();
      logic [31:0] t [3] = '{32'h0, 32'h80000000, 32'h5};
      for (int k = 0; k < 48; k++) begin
         core({2'h3, k[3:0] ^ {k[5:4], k[5:4]}, k[3:0]}, t[k % 3], {k[1] ^ k[4], k[2], 1'b0});
      end
      core(10'h311, 32'h1, 3'h2);
      for (int k = 0; k < 3; k++) begin
         core(10'h38c, t[k], 3'h0);
      end
   endtask
   // Evaluation from a register write, status, counter clear, core path disabled.
   task automatic t_apb();
      logic [7:0] s;
      core(10'h300, 32'h0, 3'h0);
      s = seen;
      apb(1'b1, 12'h000, 32'h388);
      wait_eval(s, 1'b1);
      apb(1'b0, 12'h008, 32'h0);
      check(rd, 32'h8f);
      apb(1'b0, 12'h00c, 32'h0);
      check(rd, n_met);
      apb(1'b1, 12'h00c, 32'h0);
      apb(1'b0, 12'h00c, 32'h0);
      check(rd, 32'h0);
      apb(1'b1, 12'h004, 32'h0);
      s = seen;
      @(posedge clk);
      issue <= 1'b1;
      @(posedge clk);
      issue <= 1'b0;
      repeat (8) @(posedge clk);
      check(seen, s);
      apb(1'b1, 12'h004, 32'h1);
   endtask
   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite, issue, io} = 5'h01;
      paddr = 12'h000;
      pwdata = 32'h0;
      cmd = 45'h0;
      n_mismatch = 0;
      cmp_count = 0;
      n_met = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_select();
      t_flags();
      t_apb();
      // A second reset restores the condition word.
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      check(rd, 32'h300);
      print_verdict();
   end
endmodule
bind bce_branch_cond bce_branch_cond_asserts #(.RESULT_W(RESULT_W), .COUNT_W(COUNT_W)) u_chk (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_insn_valid(i_insn_valid), .i_insn(i_insn),
   .i_result_register(i_result_register), .i_overflow(i_overflow), .i_carry(i_carry),
   .i_test_control_flag(i_test_control_flag), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
   .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_eval_valid(o_eval_valid),
   .o_cond_met(o_cond_met));
